// ===== rtl/host_port_defines.vh
// Constants for the host memory port
`ifndef HOST_PORT_DEFINES_VH
`define HOST_PORT_DEFINES_VH
`define HP_START_ADDR_OFS   14'h3FE0
`define HP_OVERLAY_OFS      14'h3FE7
`define HP_CTRL_HI_OFS      14'h3FE0
`define HP_SEL_BIT          15
`define HP_DEST_BIT         14
`define HP_ADDR_MSB         13
`define HP_OVL_MSB          7
`define HP_ADDR_W           14
`define HP_ADDR_RST         14'h0000
`define HP_OVL_RST          8'h00
`define HP_ZERO16           16'h0000
`define HP_ZERO8            8'h00
`define HP_PM_DEPTH         16384
`define HP_DM_DEPTH         16384
`define HP_BOOT_MODE        3'h5
`define HP_PM_BOOT_ADDR     14'h0000
`define HP_ST_IDLE          2'h0
`define HP_ST_SYNC          2'h1
`define HP_ST_MEM           2'h2
`define HP_ST_DONE          2'h3
`endif

// ===== rtl/host_port_buf2.v
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module host_port_buf2
(
    input  wire        clk_i,
    input  wire        nrst_i,
    input  wire [15:0] in_data_i,
    input  wire        in_valid_i,
    output wire        in_ready_o,
    output wire [15:0] out_data_o,
    output wire        out_valid_o,
    input  wire        out_ready_i
);
    reg  [15:0] mem [0:1];
    reg         wr_ptr;
    reg         rd_ptr;
    reg  [1:0]  count;
    wire        push;
    wire        pop;

    // Honest full and empty from the occupancy count
    assign in_ready_o  = (count != 2'h2);
    assign out_valid_o = (count != 2'h0);
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // Storage holds no reset; only pointers and count need one
    always @(posedge clk_i)
    begin
        if (push)
            mem[wr_ptr] <= in_data_i;
    end

    // Pointers and occupancy
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end
        else
        begin
            if (push)
                wr_ptr <= ~wr_ptr;
            if (pop)
                rd_ptr <= ~rd_ptr;
            if (push & ~pop)
                count <= count + 2'h1;
            else if (pop & ~push)
                count <= count - 2'h1;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/host_memory_port.v
// Host memory port: strobe decode, address/overlay latch, memories, boot hold
//
// Operation
// - One processor memory cycle spent per bus word moved.
// - Host writes never reach memory-mapped control registers.
// - Bus bit 15 set: bits 7..0 are overlay, 14..8 zero.
// - Bus bit 15 clear: bits 13..0 address, bit 14 program/data.
// - One 16-bit bus carries address, data and 24-bit program words.
// - Strobes treated as synchronous to the clock; one register stage finds edges.
// - Latched address increments after every data word and after the low byte of each program word.
// - Start address captured on falling edge of address latch.
// - One cycle to synchronise, then one cycle memory access.
// - Processor may write start address register itself.
// - Address and overlay held separately; address at data 0x3FE0.
// - Host cannot read back the latched start address.
// - Overlay register mapped at data location 0x3FE7.
// - Mode pins C=1 B=0 A=1 at reset select port boot.
// - Port boot holds execution until program location 0 written.
`timescale 1ns/1ps
`default_nettype none
`include "host_port_defines.vh"
module host_memory_port
(
    input  wire        clk_i,
    input  wire        nrst_i,
    input  wire        host_port_select_n_i,
    input  wire        host_addr_latch_strobe_i,
    input  wire        host_read_strobe_n_i,
    input  wire        host_write_strobe_n_i,
    input  wire [15:0] host_addr_data_bus_i,
    output reg  [15:0] host_addr_data_bus_o,
    output reg         host_addr_data_bus_oe_o,
    output reg         host_access_ack_n_o,
    input  wire [2:0]  boot_mode_i,
    input  wire        cpu_reg_wr_i,
    input  wire [13:0] cpu_reg_addr_i,
    input  wire [15:0] cpu_reg_wdata_i,
    output reg  [15:0] cpu_reg_rdata_o,
    output reg         cpu_halt_o,
    output reg  [15:0] rd_word_o,
    output reg         rd_valid_o,
    input  wire        rd_ready_i
);
    // Memories and port state
    reg  [23:0] program_memory [0:`HP_PM_DEPTH-1];
    reg  [15:0] data_memory    [0:`HP_DM_DEPTH-1];
    reg  [13:0] start_addr;
    reg         dest_dm;
    reg  [7:0]  memory_overlay_select;
    reg  [1:0]  state;
    reg         is_write;
    reg         pm_low_phase;
    reg  [15:0] pm_hi_hold;
    reg  [7:0]  pm_rd_low;
    reg         boot_pending;
    reg         mode_taken;
    reg         al_q;
    reg         rd_q;
    reg         wr_q;
    reg  [15:0] wdata;
    wire        al_fall;
    wire        rd_req;
    wire        wr_req;
    wire [15:0] buf_data;
    wire        buf_valid;
    wire        buf_in_ready;
    reg  [15:0] rd_word_next;
    reg         push_rd;

    // Control-register window that the host may not write
    function is_ctrl_reg;
        input [13:0] a;
        begin
            is_ctrl_reg = (a >= `HP_CTRL_HI_OFS);
        end
    endfunction

    // Strobes treated as synchronous inputs; one stage finds edges
    // Edge detect on strobes
    assign al_fall = al_q & ~host_addr_latch_strobe_i;
    assign rd_req  = ~host_port_select_n_i & ~host_read_strobe_n_i & rd_q;
    assign wr_req  = ~host_port_select_n_i & ~host_write_strobe_n_i & wr_q;

    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            al_q <= 1'b0;
            rd_q <= 1'b1;
            wr_q <= 1'b1;
        end
        else
        begin
            al_q <= host_addr_latch_strobe_i & ~host_port_select_n_i;
            // Keep a read edge alive while the buffer is full, else it is lost
            rd_q <= host_read_strobe_n_i | host_port_select_n_i | (rd_req & ~buf_in_ready);
            wr_q <= host_write_strobe_n_i | host_port_select_n_i;
        end
    end

    // Read data buffer so a stalled consumer loses no word
    host_port_buf2 u_rd_buf
    (
        .clk_i       (clk_i),
        .nrst_i      (nrst_i),
        .in_data_i   (rd_word_next),
        .in_valid_i  (push_rd),
        .in_ready_o  (buf_in_ready),
        .out_data_o  (buf_data),
        .out_valid_o (buf_valid),
        .out_ready_i (~rd_valid_o | rd_ready_i)
    );

    // Memory writes, no reset on arrays
    always @(posedge clk_i)
    begin
        if (state == `HP_ST_MEM && is_write)
        begin
            // Program word completes on low byte
            if (!dest_dm && pm_low_phase)
                program_memory[start_addr] <= {pm_hi_hold, wdata[7:0]};
            else if (dest_dm && !is_ctrl_reg(start_addr))
                data_memory[start_addr] <= wdata;
        end
        if (state == `HP_ST_MEM && !is_write && !dest_dm && !pm_low_phase)
            pm_rd_low <= program_memory[start_addr][7:0];
    end

    // Read word selection for the buffer
    always @*
    begin
        rd_word_next = `HP_ZERO16;
        push_rd      = 1'b0;
        if (state == `HP_ST_MEM && !is_write)
        begin
            push_rd = 1'b1;
            // Start address is not a readable location
            if (dest_dm && start_addr == `HP_START_ADDR_OFS)
                rd_word_next = `HP_ZERO16;
            else if (dest_dm)
                rd_word_next = data_memory[start_addr];
            else if (pm_low_phase)
                rd_word_next = {`HP_ZERO8, pm_rd_low};
            else
                rd_word_next = program_memory[start_addr][23:8];
        end
    end

    // Main sequencer: sync cycle, memory cycle, done
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state                 <= `HP_ST_IDLE;
            is_write              <= 1'b0;
            start_addr            <= `HP_ADDR_RST;
            dest_dm               <= 1'b0;
            memory_overlay_select <= `HP_OVL_RST;
            pm_low_phase          <= 1'b0;
            pm_hi_hold            <= `HP_ZERO16;
            wdata                 <= `HP_ZERO16;
            host_access_ack_n_o   <= 1'b0;
        end
        else
        begin
            case (state)
                `HP_ST_IDLE:
                begin
                    host_access_ack_n_o <= 1'b0;
                    if (al_fall)
                    begin
                        if (host_addr_data_bus_i[`HP_SEL_BIT])
                            memory_overlay_select <= host_addr_data_bus_i[`HP_OVL_MSB:0];
                        else
                        begin
                            start_addr   <= host_addr_data_bus_i[`HP_ADDR_MSB:0];
                            dest_dm      <= host_addr_data_bus_i[`HP_DEST_BIT];
                            pm_low_phase <= 1'b0;
                        end
                    end
                    else if (cpu_reg_wr_i && cpu_reg_addr_i == `HP_START_ADDR_OFS)
                    begin
                        start_addr   <= cpu_reg_wdata_i[`HP_ADDR_MSB:0];
                        dest_dm      <= cpu_reg_wdata_i[`HP_DEST_BIT];
                        pm_low_phase <= 1'b0;
                    end
                    // Overlay kept in its own register
                    else if (cpu_reg_wr_i && cpu_reg_addr_i == `HP_OVERLAY_OFS)
                        memory_overlay_select <= cpu_reg_wdata_i[`HP_OVL_MSB:0];
                    // Busy while access pending; reads wait for room
                    else if (wr_req || (rd_req && buf_in_ready))
                    begin
                        state               <= `HP_ST_SYNC;
                        is_write            <= wr_req;
                        wdata               <= host_addr_data_bus_i;
                        host_access_ack_n_o <= 1'b1;
                    end
                end
                `HP_ST_SYNC:
                    state <= `HP_ST_MEM;
                `HP_ST_MEM:
                begin
                    state <= `HP_ST_DONE;
                    // High half of a program word
                    if (!dest_dm && !pm_low_phase)
                    begin
                        pm_low_phase <= 1'b1;
                        pm_hi_hold   <= wdata;
                    end
                    else
                    begin
                        pm_low_phase <= 1'b0;
                        start_addr   <= start_addr + 14'h0001;
                    end
                end
                // Wait for strobe release so one pulse gives one access
                `HP_ST_DONE:
                begin
                    if (rd_q && wr_q)
                    begin
                        state               <= `HP_ST_IDLE;
                        host_access_ack_n_o <= 1'b0;
                    end
                end
                default:
                    state <= `HP_ST_IDLE;
            endcase
        end
    end

    // Bus drive and buffered read outputs, all registered
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            host_addr_data_bus_o    <= `HP_ZERO16;
            host_addr_data_bus_oe_o <= 1'b0;
            rd_word_o               <= `HP_ZERO16;
            rd_valid_o              <= 1'b0;
        end
        else
        begin
            host_addr_data_bus_oe_o <= ~host_port_select_n_i & ~host_read_strobe_n_i;
            if (push_rd)
                host_addr_data_bus_o <= rd_word_next;
            if (!rd_valid_o || rd_ready_i)
            begin
                rd_valid_o <= buf_valid;
                rd_word_o  <= buf_data;
            end
        end
    end

    // CPU read-back of the port registers
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            cpu_reg_rdata_o <= `HP_ZERO16;
        else if (cpu_reg_addr_i == `HP_START_ADDR_OFS)
            cpu_reg_rdata_o <= {1'b0, dest_dm, start_addr};
        else if (cpu_reg_addr_i == `HP_OVERLAY_OFS)
            cpu_reg_rdata_o <= {`HP_ZERO8, memory_overlay_select};
        else
            cpu_reg_rdata_o <= `HP_ZERO16;
    end

    // Boot mode taken one edge after reset release
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            mode_taken   <= 1'b0;
            boot_pending <= 1'b0;
            cpu_halt_o   <= 1'b1;
        end
        else
        begin
            if (!mode_taken)
            begin
                mode_taken <= 1'b1;
                boot_pending <= (boot_mode_i == `HP_BOOT_MODE);
                cpu_halt_o   <= (boot_mode_i == `HP_BOOT_MODE);
            end
            // Release on program location 0 write
            else if (boot_pending && state == `HP_ST_MEM && is_write && !dest_dm
                     && pm_low_phase && start_addr == `HP_PM_BOOT_ADDR)
            begin
                boot_pending <= 1'b0;
                cpu_halt_o   <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== bench/host_memory_port_assertions.sv
// Assertion checker for the host memory port
`timescale 1ns/1ps
`default_nettype none
module host_memory_port_checker
(
    input wire logic        clk_i,
    input wire logic        nrst_i,
    input wire logic        host_port_select_n_i,
    input wire logic        host_read_strobe_n_i,
    input wire logic        host_write_strobe_n_i,
    input wire logic        host_addr_data_bus_oe_o,
    input wire logic        host_access_ack_n_o,
    input wire logic [2:0]  boot_mode_i,
    input wire logic [13:0] cpu_reg_addr_i,
    input wire logic [15:0] cpu_reg_rdata_o,
    input wire logic        cpu_halt_o,
    input wire logic [15:0] rd_word_o,
    input wire logic        rd_valid_o,
    input wire logic        rd_ready_i
);
    logic [1:0] cyc;
    wire logic  no_strb = host_read_strobe_n_i & host_write_strobe_n_i;
    // Cycles since reset, saturating so it never wraps
    always @(posedge clk_i or negedge nrst_i)
        if (!nrst_i)
            cyc <= 2'h0;
        else if (cyc != 2'h3)
            cyc <= cyc + 2'h1;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    AST_ACK_RISE: assert property (!host_port_select_n_i && !host_write_strobe_n_i
        && $past(host_write_strobe_n_i) && !host_access_ack_n_o |-> ##[1:2] host_access_ack_n_o)
        else $error("ack did not go busy after a write");
    AST_ACK_HOLD: assert property (host_access_ack_n_o && !no_strb |=> host_access_ack_n_o)
        else $error("ack freed while strobe held");
    // Strobes seen released on two edges: ack must free within two more
    AST_ACK_FREE: assert property (host_access_ack_n_o && no_strb && $past(no_strb)
        |-> ##[1:2] !host_access_ack_n_o)
        else $error("ack stuck busy after release");
    AST_ACK_QUIET: assert property (!host_access_ack_n_o && host_port_select_n_i
        |=> !host_access_ack_n_o)
        else $error("ack busy without select");
    AST_OE_READ: assert property (host_addr_data_bus_oe_o
        == $past(!host_port_select_n_i && !host_read_strobe_n_i))
        else $error("bus drive not tied to read");
    AST_HALT_MODE: assert property (cyc == 2'h1 |-> cpu_halt_o == (boot_mode_i == 3'h5))
        else $error("halt wrong for boot mode");
    AST_HALT_STICKY: assert property (!cpu_halt_o |=> !cpu_halt_o)
        else $error("halt rose again");
    AST_CPU_MAP: assert property (cpu_reg_addr_i != 14'h3FE0 && cpu_reg_addr_i != 14'h3FE7
        |=> cpu_reg_rdata_o == 16'h0000)
        else $error("unmapped register read not zero");
    AST_RD_HOLD: assert property (rd_valid_o && !rd_ready_i |=> rd_valid_o && $stable(rd_word_o))
        else $error("stalled read word lost");
    // Main scenarios reached
    COV_STALL: cover property (rd_valid_o && !rd_ready_i);
    COV_BOOT: cover property (cyc == 2'h3 && $fell(cpu_halt_o));
    COV_READ: cover property (host_addr_data_bus_oe_o && host_access_ack_n_o);
endmodule
bind host_memory_port host_memory_port_checker u_chk (.*);
`default_nettype wire

// ===== bench/host_model.sv
// Behavioural host processor driving the port strobes
`timescale 1ns/1ps
`default_nettype none
module host_model
(
    input  wire logic        clk_i,
    input  wire logic        ack_n_i,
    input  wire logic [15:0] bus_i,
    output var  logic        sel_n_o = 1'b1,
    output var  logic        latch_o = 1'b0,
    output var  logic        rd_n_o = 1'b1,
    output var  logic        wr_n_o = 1'b1,
    output var  logic [15:0] bus_o = 16'hFFFF
);
    // Bounded wait on acknowledge, sampled at the settled edge
    task automatic wait_ack(input logic lvl);
        int n;
        n = 0;
        while (ack_n_i !== lvl && n < 40)
        begin
            @(negedge clk_i);
            n++;
        end
        if (ack_n_i !== lvl)
            host_memory_port_tb.timed_out();
    endtask
    // Address phase only once acknowledge is low
    task automatic latch(input logic [15:0] w);
        wait_ack(1'b0);
        sel_n_o = 1'b0;
        latch_o = 1'b1;
        bus_o = w;
        @(negedge clk_i);
        latch_o = 1'b0;
        @(negedge clk_i);
        sel_n_o = 1'b1;
        bus_o = ~w;
    endtask
    // Strobe held until the access is over; released bus shows junk
    task automatic xfer(input logic wr, input logic [15:0] w, output logic [15:0] r);
        wait_ack(1'b0);
        sel_n_o = 1'b0;
        bus_o = w;
        rd_n_o = wr;
        wr_n_o = !wr;
        wait_ack(1'b1);
        repeat (4) @(negedge clk_i);
        r = bus_i;
        sel_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        bus_o = ~w;
        wait_ack(1'b0);
    endtask
endmodule
`default_nettype wire

// ===== bench/host_memory_port_tb.sv
// Testbench for the host memory port
`timescale 1ns/1ps
`default_nettype none
module host_memory_port_tb;
    logic        clk_i;
    logic        nrst_i;
    logic [2:0]  boot_mode_i;
    logic        cpu_wr;
    logic [13:0] cpu_addr;
    logic [15:0] cpu_wdata;
    logic        rd_ready;
    wire logic   sel_n, al, rd_n, wr_n, oe, ack_n, halt, rd_valid;
    wire logic [15:0] bus_h, bus_d, rdata, rd_word;
    logic [15:0] r;
    int          n_errors = 0;
    int          n_checks = 0;
    always #12.5 clk_i = ~clk_i;
    host_model u_host (.clk_i(clk_i), .ack_n_i(ack_n), .bus_i(bus_d), .sel_n_o(sel_n),
        .latch_o(al), .rd_n_o(rd_n), .wr_n_o(wr_n), .bus_o(bus_h));
    host_memory_port u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .host_port_select_n_i(sel_n),
        .host_addr_latch_strobe_i(al), .host_read_strobe_n_i(rd_n),
        .host_write_strobe_n_i(wr_n), .host_addr_data_bus_i(bus_h),
        .host_addr_data_bus_o(bus_d), .host_addr_data_bus_oe_o(oe),
        .host_access_ack_n_o(ack_n), .boot_mode_i(boot_mode_i), .cpu_reg_wr_i(cpu_wr),
        .cpu_reg_addr_i(cpu_addr), .cpu_reg_wdata_i(cpu_wdata), .cpu_reg_rdata_o(rdata),
        .cpu_halt_o(halt), .rd_word_o(rd_word), .rd_valid_o(rd_valid), .rd_ready_i(rd_ready));
    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        if (n_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic timed_out;
        n_errors++;
        $display("mismatch at %0t: wait ran out", $time);
        close_out();
    endtask
    // Reset held 8 cycles with the given boot mode
    task automatic rst(input logic [2:0] m);
        nrst_i = 1'b0;
        boot_mode_i = m;
        repeat (8) @(negedge clk_i);
        nrst_i = 1'b1;
        repeat (2) @(negedge clk_i);
    endtask
    task automatic cpu_rd(input logic [13:0] a, input logic [15:0] exp);
        cpu_addr = a;
        @(negedge clk_i);
        check(rdata, exp);
    endtask
    task automatic cpu_wr_reg(input logic [13:0] a, input logic [15:0] d);
        cpu_wr = 1'b1;
        cpu_addr = a;
        cpu_wdata = d;
        @(negedge clk_i);
        cpu_wr = 1'b0;
    endtask
    // Data block: auto increment, stalled stream keeps both words
    task automatic t_dm;
        int i;
        u_host.latch(16'h4010);
        for (i = 0; i < 3; i++)
            u_host.xfer(1'b1, 16'h1100 + 16'(i), r);
        u_host.latch(16'h4010);
        rd_ready = 1'b0;
        u_host.xfer(1'b0, 16'h0000, r);
        check(r, 16'h1100);
        u_host.xfer(1'b0, 16'h0000, r);
        check(r, 16'h1101);
        check({15'h0, rd_valid}, 16'h0001);
        check(rd_word, 16'h1100);
        rd_ready = 1'b1;
        @(negedge clk_i);
        check(rd_word, 16'h1101);
        @(negedge clk_i);
        check({15'h0, rd_valid}, 16'h0000);
        u_host.xfer(1'b0, 16'h0000, r);
        check(r, 16'h1102);
        cpu_rd(14'h3FE0, 16'h4013);
    endtask
    // Overlay, protected window, hidden address, processor-set address
    task automatic t_regs;
        u_host.latch(16'h805A);
        cpu_rd(14'h3FE7, 16'h005A);
        u_host.latch(16'h7FE7);
        u_host.xfer(1'b1, 16'h00FF, r);
        cpu_rd(14'h3FE7, 16'h005A);
        u_host.latch(16'h7FE0);
        u_host.xfer(1'b0, 16'h0000, r);
        check(r, 16'h0000);
        cpu_wr_reg(14'h3FE0, 16'h4020);
        u_host.xfer(1'b1, 16'h2222, r);
        cpu_wr_reg(14'h3FE0, 16'h4020);
        u_host.xfer(1'b0, 16'h0000, r);
        check(r, 16'h2222);
        cpu_wr_reg(14'h3FE7, 16'h00A5);
        cpu_rd(14'h3FE7, 16'h00A5);
        cpu_rd(14'h1234, 16'h0000);
    endtask
    // Port boot: core held until program word 0 is complete
    task automatic t_boot;
        rst(3'h5);
        check({15'h0, halt}, 16'h0001);
        u_host.latch(16'h0000);
        u_host.xfer(1'b1, 16'hA1B2, r);
        check({15'h0, halt}, 16'h0001);
        u_host.xfer(1'b1, 16'h00C3, r);
        check({15'h0, halt}, 16'h0000);
        u_host.latch(16'h0000);
        u_host.xfer(1'b0, 16'h0000, r);
        check(r, 16'hA1B2);
        u_host.xfer(1'b0, 16'h0000, r);
        check(r, 16'h00C3);
    endtask
    // Main sequence; idle levels set here rather than in declarations
    initial
    begin
        clk_i = 1'b0;
        cpu_wr = 1'b0;
        cpu_addr = 14'h0000;
        cpu_wdata = 16'h0000;
        rd_ready = 1'b1;
        rst(3'h0);
        check({15'h0, halt}, 16'h0000);
        t_dm();
        t_regs();
        t_boot();
        close_out();
    end
endmodule
`default_nettype wire
